// file: inc/rsc_params.svh
// Constants for the reset source control block
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_ADDR_CLKWATCH 8'h00
`define RSC_ADDR_RESETCAUSE 8'h04
`define RSC_ADDR_LVDCTRL 8'h08
`define RSC_ADDR_RESETKIND 8'h0c
`define RSC_BIT_CW_ENABLE 0
`define RSC_BIT_CW_RESET_FLAG 1
`define RSC_BIT_WDT_RESET_FLAG 4
`define RSC_BIT_LVD_RESET_FLAG 0
`define RSC_BIT_LVD_OUT_ENABLE 1
`define RSC_BIT_LVD_ON 7
`define RSC_CAUSE_RESET 8'h00
`define RSC_CAUSE_SETTLE 2'h2
`define RSC_CLKWATCH_RESET 8'h00
`define RSC_LVDCTRL_RESET 8'h00
`endif

// file: inc/rsc_pkg.sv
// Types for the reset source control block
package rsc_pkg;
    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] dat;
        logic we;
        logic sel;
        logic req;
    } rsc_wb_req_t;
    typedef struct packed {
        logic powerOnClear;
        logic clockWatch;
        logic lowVoltage;
        logic watchdog;
        logic pin;
    } rsc_cause_t;
endpackage

// file: logic/rsc_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ns
`default_nettype none
module rsc_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    logic stage1Reg;
    logic stage2Reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1Reg <= 1'b0;
            stage2Reg <= 1'b0;
        end else begin
            stage1Reg <= d;
            stage2Reg <= stage1Reg;
        end
    end
    assign q = stage2Reg;
endmodule
`default_nettype wire

// file: logic/rsc_cause_latch.sv
// Captures which source caused the last reset
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"
module rsc_cause_latch (
    input wire logic clk,
    input wire logic rst_b,
    input wire rsc_pkg::rsc_cause_t cause,
    output logic [7:0] flags
);
    // Cause sampled once the two-flop synchronisers have settled
    logic [1:0] settleReg;
    logic [1:0] settleNext;
    logic [7:0] flagsReg;
    logic [7:0] flagsNext;
    always_comb begin
        settleNext = settleReg;
        if (settleReg != 2'h3) begin
            settleNext = settleReg + 2'h1;
        end
        flagsNext = flagsReg;
        if (settleReg == `RSC_CAUSE_SETTLE) begin
            if (cause.powerOnClear) begin
                flagsNext = `RSC_CAUSE_RESET; // RL4
            end else begin
                flagsNext = `RSC_CAUSE_RESET;
                flagsNext[`RSC_BIT_CW_RESET_FLAG] = cause.clockWatch; // RL3
                flagsNext[`RSC_BIT_WDT_RESET_FLAG] = cause.watchdog;
                flagsNext[`RSC_BIT_LVD_RESET_FLAG] = cause.lowVoltage;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settleReg <= 2'h0;
            flagsReg <= `RSC_CAUSE_RESET;
        end else begin
            settleReg <= settleNext;
            flagsReg <= flagsNext; // RL8
        end
    end
    assign flags = flagsReg;
endmodule
`default_nettype wire

// file: logic/rsc_reset_source_control.sv
// Reset source control: clock watch enable, reset cause flags, detector control
// Functional notes
// RL1 - Clock watch enable cannot be cleared by software
// RL2 - Clock watch reset clears the enable bit
// RL3 - Clock watch reset sets its cause flag
// RL4 - Power-on clear zeroes all cause flags
// RL5 - Software stops detector writing zero byte
// RL6 - Software clears detector on before output enable
// RL7 - Software reads cause flags byte-wide only
// RL8 - Cause flags hold until next reset
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"
module rsc_reset_source_control (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic causePowerOnClear,
    input wire logic causeClockWatch,
    input wire logic causeLowVoltage,
    input wire logic causeWatchdog,
    output logic clockWatchEnable,
    output logic lowVoltageDetectOn,
    output logic lowVoltageDetectOutEnable
);
    // ----------------------------------------
    // Cause inputs from outside the clock domain
    // ----------------------------------------
    rsc_pkg::rsc_cause_t causeSync;
    rsc_pkg::rsc_wb_req_t busReq;
    logic [7:0] causeFlags;
    rsc_sync uSyncPoc (.clk(clk), .rst_b(rst_b), .d(causePowerOnClear),
        .q(causeSync.powerOnClear));
    rsc_sync uSyncCw (.clk(clk), .rst_b(rst_b), .d(causeClockWatch),
        .q(causeSync.clockWatch));
    rsc_sync uSyncLv (.clk(clk), .rst_b(rst_b), .d(causeLowVoltage),
        .q(causeSync.lowVoltage));
    rsc_sync uSyncWd (.clk(clk), .rst_b(rst_b), .d(causeWatchdog),
        .q(causeSync.watchdog));
    assign causeSync.pin = 1'b0;
    rsc_cause_latch uCause (.clk(clk), .rst_b(rst_b), .cause(causeSync),
        .flags(causeFlags));

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    assign busReq.adr = wb_adr_i;
    assign busReq.dat = wb_dat_i[7:0];
    assign busReq.we = wb_we_i;
    assign busReq.sel = wb_sel_i[0];
    assign busReq.req = wb_cyc_i & wb_stb_i;

    logic ackReg;
    logic ackNext;
    logic [31:0] datReg;
    logic [31:0] datNext;
    logic cwEnReg;
    logic cwEnNext;
    logic [7:0] lvdReg;
    logic [7:0] lvdNext;

    function automatic logic isWrite(input rsc_pkg::rsc_wb_req_t r, input logic [7:0] a);
        isWrite = r.req & r.we & r.sel & (r.adr == a);
    endfunction

    always_comb begin
        ackNext = busReq.req & ~ackReg;
        datNext = 32'h0000_0000;
        cwEnNext = cwEnReg;
        lvdNext = lvdReg;
        if (busReq.req && !ackReg && !busReq.we) begin
            unique case (busReq.adr)
                `RSC_ADDR_CLKWATCH: datNext = {31'h0, cwEnReg};
                `RSC_ADDR_RESETCAUSE: datNext = {24'h0, causeFlags}; // RL7
                `RSC_ADDR_LVDCTRL: datNext = {24'h0, lvdReg};
                default: datNext = 32'h0000_0000;
            endcase
        end
        if (!ackReg && isWrite(busReq, `RSC_ADDR_CLKWATCH)) begin
            // Set only; a written zero is ignored
            cwEnNext = cwEnReg | busReq.dat[`RSC_BIT_CW_ENABLE]; // RL1
        end
        if (!ackReg && isWrite(busReq, `RSC_ADDR_LVDCTRL)) begin
            // A zero byte stops the detector at once
            lvdNext = busReq.dat; // RL5
            // Output enable held while detector still on
            if (lvdReg[`RSC_BIT_LVD_ON] && busReq.dat[`RSC_BIT_LVD_ON]) begin
                lvdNext[`RSC_BIT_LVD_OUT_ENABLE] =
                    lvdReg[`RSC_BIT_LVD_OUT_ENABLE] | busReq.dat[`RSC_BIT_LVD_OUT_ENABLE]; // RL6
            end
        end
    end

    // Every reset, clock watch one included, clears the enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ackReg <= 1'b0;
            datReg <= 32'h0000_0000;
            cwEnReg <= 1'b0; // RL2
            lvdReg <= `RSC_LVDCTRL_RESET;
        end else begin
            ackReg <= ackNext;
            datReg <= datNext;
            cwEnReg <= cwEnNext;
            lvdReg <= lvdNext;
        end
    end

    assign wb_ack_o = ackReg;
    assign wb_dat_o = datReg;
    assign clockWatchEnable = cwEnReg;
    assign lowVoltageDetectOn = lvdReg[`RSC_BIT_LVD_ON];
    assign lowVoltageDetectOutEnable = lvdReg[`RSC_BIT_LVD_OUT_ENABLE];
endmodule
`default_nettype wire

// file: tb/rsc_check_sva.sv
// Checker for the reset source control ports
`timescale 1ns/1ns
`default_nettype none
module rsc_check_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic causePowerOnClear,
    input wire logic causeClockWatch,
    input wire logic causeLowVoltage,
    input wire logic causeWatchdog,
    input wire logic clockWatchEnable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence causeRd;
        wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 8'h04 && !wb_ack_o ##1 wb_ack_o;
    endsequence
    AST_EN_STICKY: assert property ($past(clockWatchEnable) |-> clockWatchEnable)
        else $error("enable fell without reset");
    AST_EN_RESET: assert property ($rose(rst_b) |-> !clockWatchEnable)
        else $error("enable set after reset");
    AST_CW_FLAG: assert property (causeRd |-> causePowerOnClear || wb_dat_o[1] == causeClockWatch)
        else $error("clock watch flag wrong");
    AST_POC_ZERO: assert property (causeRd |-> !causePowerOnClear || wb_dat_o[7:0] == 8'h00)
        else $error("flags not zero after power-on clear");
    AST_FLAG_HOLD: assert property (causeRd |-> causePowerOnClear || (wb_dat_o[7:0] & 8'h13) ==
        {3'h0, causeWatchdog, 2'h0, causeClockWatch, causeLowVoltage})
        else $error("cause flags not held");
endmodule
bind rsc_reset_source_control rsc_check_sva u_sva (.clk, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .causePowerOnClear, .causeClockWatch,
    .causeLowVoltage, .causeWatchdog, .clockWatchEnable);
`default_nettype wire

// file: tb/rsc_reset_source_control_bench.sv
// Self-checking bench for reset source control
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin badCount++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module rsc_reset_source_control_bench;
    logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0, ack, cwEn, lvOn, lvOe;
    logic [7:0] adr = 8'h00;
    logic [31:0] datI = 32'h0, datO, rd;
    logic [3:0] sel = 4'h0, cause = 4'h0, c;
    logic [7:0] lvW [6] = '{8'h82, 8'h00, 8'h82, 8'h80, 8'h02, 8'h00};
    logic [1:0] lvE [6] = '{2'h3, 2'h0, 2'h3, 2'h3, 2'h1, 2'h0};
    logic [3:0] corner [4] = '{4'h4, 4'hf, 4'h3, 4'h0};
    int badCount = 0, nCompared = 0, seed = 61102;
    always #5 clk = ~clk;
    rsc_reset_source_control u_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(datI), .wb_sel_i(sel), .wb_dat_o(datO),
        .wb_ack_o(ack), .causePowerOnClear(cause[3]), .causeClockWatch(cause[2]),
        .causeLowVoltage(cause[1]), .causeWatchdog(cause[0]), .clockWatchEnable(cwEn),
        .lowVoltageDetectOn(lvOn), .lowVoltageDetectOutEnable(lvOe));
    function automatic logic [7:0] expFlags(input logic [3:0] k);
        return k[3] ? 8'h00 : {3'h0, k[0], 2'h0, k[2], k[1]};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
        @(posedge clk);
        {req, we, adr, datI, sel} <= {1'b1, w, a, 24'h0, d, 3'h0, s};
        do @(posedge clk); while (ack !== 1'b1);
        rd = datO;
        req <= 1'b0;
    endtask
    task automatic stopTest();
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 12; i++) begin
            c = (i < 4) ? corner[i] : 4'($random(seed));
            @(posedge clk);
            rst_b <= 1'b0;
            cause <= c;
            repeat (5) @(posedge clk);
            rst_b <= 1'b1;
            repeat (5) @(posedge clk);
            `CHK("enable", 1'b0, cwEn)
            bus(1'b0, 8'h04, 8'h00, 1'b1);
            `CHK("flags", {24'h0, expFlags(c)}, rd)
            bus(1'b1, 8'h00, 8'h01, 1'b0);
            `CHK("enable no sel", 1'b0, cwEn)
            bus(1'b1, 8'h00, 8'h01, 1'b1);
            bus(1'b1, 8'h00, 8'h00, 1'b1);
            bus(1'b0, 8'h00, 8'h00, 1'b1);
            `CHK("enable reg", 32'h1, rd)
            bus(1'b1, 8'h0c, 8'hff, 1'b1);
            bus(1'b0, 8'h0c, 8'h00, 1'b1);
            `CHK("unmapped", 32'h0, rd)
            for (int j = 0; j < 6; j++) begin
                bus(1'b1, 8'h08, lvW[j], 1'b1);
                @(posedge clk);
                `CHK("detector", lvE[j], {lvOn, lvOe})
            end
            bus(1'b0, 8'h04, 8'h00, 1'b1);
            `CHK("flags held", {24'h0, expFlags(c)}, rd)
            $display("test %0d cause %h done", i, c);
        end
        stopTest();
    end
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        stopTest();
    end
endmodule
`default_nettype wire
